// ==== dcsp_unit.sv ====
`include "dcsp_map.svh"
`timescale 1ns/100ps
`default_nettype none

module dcsp_unit
  import dcsp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Network port register access
  input wire logic [11:0] net_addr,
  input wire logic net_wr,
  input wire logic net_rd,
  input wire logic [7:0] net_wdata,
  input wire logic net_frame_end,
  output logic [7:0] net_rdata_ff,
  // Host data interface register access
  input wire logic [11:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  input wire logic host_frame_end,
  input wire logic host_write_ack_en,
  // Ownership and activation bits held elsewhere
  input wire logic sync_owner_host,
  input wire logic capture_zero_owner_host,
  input wire logic capture_one_owner_host,
  input wire logic unit_active,
  input wire logic auto_activate,
  // System time and capture pin
  input wire logic [63:0] system_time,
  input wire logic capture_input_zero,
  // Sync pulses and side effects
  output logic primary_sync_pulse_ff,
  output logic secondary_sync_pulse_ff,
  output logic activate_set_ff,
  output logic application_event_request_clear_ff
);

  // ===================================================================
  // Reset release
  logic rst_meta_ff;
  logic rst_sync_b_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_b_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_b_ff <= rst_meta_ff;
    end
  end

  // ===================================================================
  // State
  logic [63:0] start_next_ff;
  logic [63:0] sec_next_ff;
  logic [31:0] prim_cycle_ff;
  logic [31:0] sec_cycle_ff;
  logic [1:0] ctl_zero_ff;
  logic [1:0] ctl_one_ff;
  logic [1:0] stat_zero_ff;
  logic [63:0] rise_time_ff;
  logic [63:0] fall_time_ff;
  logic pin_ff;
  logic lo_seen_ff;
  logic hi_seen_ff;
  logic sec_armed_ff;
  logic sec_first_ff;
  dcsp_state_t state_ff;
  dcsp_state_t nxt_state;

  // ===================================================================
  // Owner port selection for the sync registers
  logic sw_wr;
  logic [11:0] sw_addr;
  logic [7:0] sw_wdata;
  logic sw_frame_end;

  assign sw_wr = sync_owner_host ? host_wr : net_wr;
  assign sw_addr = sync_owner_host ? host_addr : net_addr;
  assign sw_wdata = sync_owner_host ? host_wdata : net_wdata;
  assign sw_frame_end = sync_owner_host ? host_frame_end : net_frame_end;

  // ===================================================================
  // Byte access helpers
  function automatic logic [7:0] byte_of64(input logic [63:0] v, input logic [2:0] idx);
    byte_of64 = v[{idx, 3'h0} +: 8];
  endfunction : byte_of64

  function automatic logic [7:0] read_byte(input logic [11:0] a);
    if (a[11:3] == `DCSP_OFS_CYCLIC_START >> 3) begin
      read_byte = byte_of64(start_next_ff, a[2:0]);
    end else if (a[11:3] == `DCSP_OFS_NEXT_SECONDARY >> 3) begin
      read_byte = byte_of64(sec_next_ff, a[2:0]);
    end else if (a[11:2] == `DCSP_OFS_PRIMARY_CYCLE >> 2) begin
      read_byte = byte_of64({32'h0, prim_cycle_ff}, {1'b0, a[1:0]});
    end else if (a[11:2] == `DCSP_OFS_SECONDARY_CYCLE >> 2) begin
      read_byte = byte_of64({32'h0, sec_cycle_ff}, {1'b0, a[1:0]});
    end else if (a == `DCSP_OFS_CAPTURE_ZERO_CTL) begin
      read_byte = {6'h00, ctl_zero_ff};
    end else if (a == `DCSP_OFS_CAPTURE_ONE_CTL) begin
      read_byte = {6'h00, ctl_one_ff};
    end else if (a == `DCSP_OFS_CAPTURE_ZERO_STAT) begin
      read_byte = {5'h00, pin_ff, stat_zero_ff};
    end else if (a == `DCSP_OFS_SECONDARY_STATUS) begin
      read_byte = {7'h00, sec_first_ff};
    end else if (a[11:3] == `DCSP_OFS_ZERO_RISE_TIME >> 3) begin
      read_byte = byte_of64(rise_time_ff, a[2:0]);
    end else if (a[11:3] == `DCSP_OFS_ZERO_FALL_TIME >> 3) begin
      read_byte = byte_of64(fall_time_ff, a[2:0]);
    end else begin
      read_byte = 8'h00;
    end
  endfunction : read_byte

  // ===================================================================
  // Sync register writes
  logic start_wr;
  logic prim_cyc_wr;
  logic sec_cyc_wr;
  logic [63:0] start_merge;
  logic [31:0] prim_merge;
  logic [31:0] sec_merge;
  logic lo_now;
  logic hi_now;
  logic extend;
  logic [31:0] ext_upper;
  logic [63:0] start_written;
  logic start_touched;

  assign start_wr = sw_wr && !unit_active &&
    (sw_addr[11:3] == `DCSP_OFS_CYCLIC_START >> 3);
  assign prim_cyc_wr = sw_wr && (sw_addr[11:2] == `DCSP_OFS_PRIMARY_CYCLE >> 2);
  assign sec_cyc_wr = sw_wr && (sw_addr[11:2] == `DCSP_OFS_SECONDARY_CYCLE >> 2);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_start_lane
      assign start_merge[gi*8 +: 8] = (start_wr && sw_addr[2:0] == 3'(gi)) ?
        sw_wdata : start_next_ff[gi*8 +: 8];
    end
    for (gi = 0; gi < 4; gi++) begin : g_cycle_lane
      assign prim_merge[gi*8 +: 8] = (prim_cyc_wr && sw_addr[1:0] == 2'(gi)) ?
        sw_wdata : prim_cycle_ff[gi*8 +: 8];
      assign sec_merge[gi*8 +: 8] = (sec_cyc_wr && sw_addr[1:0] == 2'(gi)) ?
        sw_wdata : sec_cycle_ff[gi*8 +: 8];
    end
  endgenerate

  // When auto_activate is set, a frame that writes only the low half is placed in the near future.
  assign lo_now = lo_seen_ff || (start_wr && !sw_addr[2]);
  assign hi_now = hi_seen_ff || (start_wr && sw_addr[2]);
  assign extend = sw_frame_end && auto_activate && lo_now && !hi_now;
  assign ext_upper = system_time[63:32] +
    {31'h0, (start_merge[31:0] < system_time[31:0])};
  assign start_written = extend ? {ext_upper, start_merge[31:0]} : start_merge;
  assign start_touched = sw_frame_end && auto_activate && (lo_now || hi_now);

  // ===================================================================
  // Sync sequencer
  logic prim_hit;
  logic prim_fire;
  logic sec_fire;
  logic [63:0] prim_advanced;

  assign prim_hit = system_time >= start_next_ff;
  assign prim_fire = (state_ff == DCSP_ST_WAIT || state_ff == DCSP_ST_RUN) && prim_hit;
  assign sec_fire = sec_armed_ff && unit_active && (system_time >= sec_next_ff);
  assign prim_advanced = start_next_ff + {32'h0, prim_cycle_ff};

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      DCSP_ST_IDLE: begin
        if (unit_active) begin
          nxt_state = DCSP_ST_WAIT;
        end
      end
      DCSP_ST_WAIT, DCSP_ST_RUN: begin
        if (!unit_active) begin
          nxt_state = DCSP_ST_IDLE;
        end else if (prim_fire) begin
          nxt_state = (prim_cycle_ff == 32'h0) ? DCSP_ST_DONE : DCSP_ST_RUN;
        end
      end
      DCSP_ST_DONE: begin
        if (!unit_active) begin
          nxt_state = DCSP_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      state_ff <= DCSP_ST_IDLE;
      start_next_ff <= `DCSP_RST_TIME64;
      sec_next_ff <= `DCSP_RST_TIME64;
      prim_cycle_ff <= `DCSP_RST_CYCLE;
      sec_cycle_ff <= `DCSP_RST_CYCLE;
      lo_seen_ff <= 1'b0;
      hi_seen_ff <= 1'b0;
      sec_armed_ff <= 1'b0;
      sec_first_ff <= 1'b0;
      primary_sync_pulse_ff <= 1'b0;
      secondary_sync_pulse_ff <= 1'b0;
      activate_set_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      prim_cycle_ff <= prim_merge;
      sec_cycle_ff <= sec_merge;
      lo_seen_ff <= lo_now && !sw_frame_end;
      hi_seen_ff <= hi_now && !sw_frame_end;
      activate_set_ff <= start_touched && !unit_active;
      primary_sync_pulse_ff <= prim_fire;
      secondary_sync_pulse_ff <= sec_fire;
      if (prim_fire) begin
        start_next_ff <= prim_advanced;
        sec_next_ff <= start_next_ff + {32'h0, sec_cycle_ff};
        sec_armed_ff <= 1'b1;
      end else begin
        start_next_ff <= start_written;
        sec_armed_ff <= sec_armed_ff && !sec_fire && unit_active;
      end
      if (state_ff == DCSP_ST_IDLE && unit_active) begin
        sec_first_ff <= 1'b1;
      end else if (sec_fire || !unit_active) begin
        sec_first_ff <= 1'b0;
      end
    end
  end

  // ===================================================================
  // Capture input zero, and the capture input one control
  logic rise;
  logic fall;
  logic zero_owner_wr;
  logic one_owner_wr;
  logic [11:0] zero_owner_addr;
  logic [7:0] zero_owner_wdata;
  logic [11:0] one_owner_addr;
  logic [7:0] one_owner_wdata;
  logic clr_rise;
  logic clr_fall;
  logic take_rise;
  logic take_fall;

  assign rise = capture_input_zero && !pin_ff;
  assign fall = !capture_input_zero && pin_ff;
  assign zero_owner_wr = capture_zero_owner_host ? host_wr : net_wr;
  assign zero_owner_addr = capture_zero_owner_host ? host_addr : net_addr;
  assign zero_owner_wdata = capture_zero_owner_host ? host_wdata : net_wdata;
  assign one_owner_wr = capture_one_owner_host ? host_wr : net_wr;
  assign one_owner_addr = capture_one_owner_host ? host_addr : net_addr;
  assign one_owner_wdata = capture_one_owner_host ? host_wdata : net_wdata;

  // The owner's read of the low byte clears a flag; write-ack hosts clear by write.
  assign clr_rise = capture_zero_owner_host ?
    ((host_write_ack_en ? host_wr : host_rd) && host_addr == `DCSP_OFS_ZERO_RISE_TIME) :
    (net_rd && net_addr == `DCSP_OFS_ZERO_RISE_TIME);
  assign clr_fall = capture_zero_owner_host ?
    ((host_write_ack_en ? host_wr : host_rd) && host_addr == `DCSP_OFS_ZERO_FALL_TIME) :
    (net_rd && net_addr == `DCSP_OFS_ZERO_FALL_TIME);
  assign take_rise = rise && !(ctl_zero_ff[`DCSP_CTL_RISE_SINGLE] &&
    stat_zero_ff[`DCSP_STAT_RISE_EVENT]);
  assign take_fall = fall && !(ctl_zero_ff[`DCSP_CTL_FALL_SINGLE] &&
    stat_zero_ff[`DCSP_STAT_FALL_EVENT]);

  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      pin_ff <= 1'b0;
      ctl_zero_ff <= `DCSP_RST_CTL;
      ctl_one_ff <= `DCSP_RST_CTL;
      stat_zero_ff <= `DCSP_RST_STAT;
      rise_time_ff <= `DCSP_RST_TIME64;
      fall_time_ff <= `DCSP_RST_TIME64;
    end else begin
      pin_ff <= capture_input_zero;
      if (zero_owner_wr && zero_owner_addr == `DCSP_OFS_CAPTURE_ZERO_CTL) begin
        ctl_zero_ff <= zero_owner_wdata[1:0];
      end
      if (one_owner_wr && one_owner_addr == `DCSP_OFS_CAPTURE_ONE_CTL) begin
        ctl_one_ff <= one_owner_wdata[1:0];
      end
      if (take_rise) begin
        rise_time_ff <= system_time;
      end
      if (take_fall) begin
        fall_time_ff <= system_time;
      end
      // A capture in the same cycle as a clearing read wins.
      stat_zero_ff[`DCSP_STAT_RISE_EVENT] <= (rise && ctl_zero_ff[`DCSP_CTL_RISE_SINGLE]) ||
        (stat_zero_ff[`DCSP_STAT_RISE_EVENT] && !clr_rise);
      stat_zero_ff[`DCSP_STAT_FALL_EVENT] <= (fall && ctl_zero_ff[`DCSP_CTL_FALL_SINGLE]) ||
        (stat_zero_ff[`DCSP_STAT_FALL_EVENT] && !clr_fall);
    end
  end

  // ===================================================================
  // Read data and acknowledge side effects
  logic sec_stat_ack;

  assign sec_stat_ack = (host_write_ack_en ? host_wr : host_rd) &&
    host_addr == `DCSP_OFS_SECONDARY_STATUS;

  always_ff @(posedge clock or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      net_rdata_ff <= 8'h00;
      application_event_request_clear_ff <= 1'b0;
    end else begin
      if (net_rd) begin
        net_rdata_ff <= read_byte(net_addr);
      end
      application_event_request_clear_ff <= sec_stat_ack;
    end
  end

  // ===================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_b_ff);

  a_start_write_lock: assert property (unit_active && !prim_fire |=> $stable(start_next_ff))
    else $error("start time changed while unit active");
  a_owner_cycle_write: assert property (
    net_wr && sync_owner_host && !host_wr |=> $stable(prim_cycle_ff) && $stable(sec_cycle_ff))
    else $error("non-owner port changed a cycle time");
  a_next_advance: assert property (
    prim_fire && prim_cycle_ff != 32'h0 |=> start_next_ff == $past(start_next_ff) + {32'h0, $past(prim_cycle_ff)})
    else $error("next primary time not advanced by one cycle");
  a_pulse_on_time: assert property (
    primary_sync_pulse_ff |-> $past(system_time) >= $past(start_next_ff))
    else $error("primary pulse before start time");
  a_single_shot: assert property (
    prim_fire && prim_cycle_ff == 32'h0 && unit_active |=> state_ff == DCSP_ST_DONE ##1 !primary_sync_pulse_ff)
    else $error("single shot emitted a second pulse");
  a_auto_activate: assert property (
    start_touched && !unit_active |=> activate_set_ff)
    else $error("auto activation not signalled");
  a_single_rise_hold: assert property (
    rise && ctl_zero_ff[0] && stat_zero_ff[0] |=> $stable(rise_time_ff))
    else $error("single event rise capture overwritten");
  a_rise_flag_set: assert property (
    rise && ctl_zero_ff[0] |=> stat_zero_ff[0] ##1 (stat_zero_ff[0] || $past(clr_rise)))
    else $error("single rise flag not set");
  a_fall_flag_set: assert property (
    fall && ctl_zero_ff[1] |=> stat_zero_ff[1])
    else $error("single fall flag not set");
  a_event_clear: assert property (
    host_rd && !host_write_ack_en && host_addr == `DCSP_OFS_SECONDARY_STATUS
    |=> application_event_request_clear_ff)
    else $error("host read did not clear event request");
  a_secondary_ro: assert property (
    net_wr && net_addr[11:3] == `DCSP_OFS_NEXT_SECONDARY >> 3 && !prim_fire |=> $stable(sec_next_ff))
    else $error("next secondary time was written");

endmodule : dcsp_unit

`default_nettype wire

// ==== dcsp_map.svh ====
`ifndef DCSP_MAP_SVH
`define DCSP_MAP_SVH

// =====================================================================
// Register byte offsets
`define DCSP_OFS_SECONDARY_STATUS 12'h98f
`define DCSP_OFS_CYCLIC_START 12'h990
`define DCSP_OFS_NEXT_SECONDARY 12'h998
`define DCSP_OFS_PRIMARY_CYCLE 12'h9a0
`define DCSP_OFS_SECONDARY_CYCLE 12'h9a4
`define DCSP_OFS_CAPTURE_ZERO_CTL 12'h9a8
`define DCSP_OFS_CAPTURE_ONE_CTL 12'h9a9
`define DCSP_OFS_CAPTURE_ZERO_STAT 12'h9ae
`define DCSP_OFS_ZERO_RISE_TIME 12'h9b0
`define DCSP_OFS_ZERO_FALL_TIME 12'h9b8

// =====================================================================
// Field positions
`define DCSP_CTL_RISE_SINGLE 0
`define DCSP_CTL_FALL_SINGLE 1
`define DCSP_STAT_RISE_EVENT 0
`define DCSP_STAT_FALL_EVENT 1
`define DCSP_STAT_PIN 2
`define DCSP_SEC_STAT_PENDING 0

// =====================================================================
// Reset values
`define DCSP_RST_TIME64 64'h0
`define DCSP_RST_CYCLE 32'h0
`define DCSP_RST_CTL 2'h0
`define DCSP_RST_STAT 2'h0

`endif

// ==== dcsp_pkg.sv ====
package dcsp_pkg;

  // ===================================================================
  // Sync output sequencer states
  typedef enum logic [1:0] {
    DCSP_ST_IDLE = 2'b00,
    DCSP_ST_WAIT = 2'b01,
    DCSP_ST_RUN = 2'b10,
    DCSP_ST_DONE = 2'b11
  } dcsp_state_t;

endpackage : dcsp_pkg

// ==== dcsp_time_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// System time source seen by the unit: a free counter in nanoseconds.
// The base sits above 2^32 so that the upper half of a time is nonzero.
module dcsp_time_model #(
  parameter logic [63:0] BASE = 64'h0000_0005_0000_0000,
  parameter logic [63:0] STEP = 64'h0000_0000_0000_000a
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Time output
  output logic [63:0] system_time
);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      system_time <= BASE;
    end else begin
      system_time <= system_time + STEP;
    end
  end
endmodule : dcsp_time_model

`default_nettype wire

// ==== dcsp_unit_test.sv ====
`include "dcsp_map.svh"
`timescale 1ns/100ps
`default_nettype none

module dcsp_unit_test;
  import dcsp_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] net_addr = 12'h0;
  logic net_wr = 1'b0;
  logic net_rd = 1'b0;
  logic [7:0] net_wdata = 8'h0;
  logic net_frame_end = 1'b0;
  logic [7:0] net_rdata_ff;
  logic [11:0] host_addr = 12'h0;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [7:0] host_wdata = 8'h0;
  logic host_frame_end = 1'b0;
  logic host_write_ack_en = 1'b1;
  logic sync_owner_host = 1'b0;
  logic capture_zero_owner_host = 1'b0;
  logic capture_one_owner_host = 1'b0;
  logic unit_active = 1'b0;
  logic auto_activate = 1'b0;
  logic [63:0] system_time;
  logic capture_input_zero = 1'b0;
  logic primary_sync_pulse_ff;
  logic secondary_sync_pulse_ff;
  logic activate_set_ff;
  logic application_event_request_clear_ff;
  logic [63:0] d;
  logic [63:0] t;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int last_prim = 0;
  int prim_gap = 0;
  int sec_gap = 0;
  int p_cnt = 0;
  int s_cnt = 0;
  int act_cnt = 0;
  int app_cnt = 0;

  always #5 clock = ~clock;

  dcsp_time_model u_time (.clock, .rst_b, .system_time);

  dcsp_unit u_dut (.clock, .rst_b, .net_addr, .net_wr, .net_rd, .net_wdata, .net_frame_end,
    .net_rdata_ff, .host_addr, .host_wr, .host_rd, .host_wdata, .host_frame_end,
    .host_write_ack_en, .sync_owner_host, .capture_zero_owner_host, .capture_one_owner_host,
    .unit_active, .auto_activate, .system_time, .capture_input_zero, .primary_sync_pulse_ff,
    .secondary_sync_pulse_ff, .activate_set_ff, .application_event_request_clear_ff);

  // ===================================================================
  // Pulse monitor and hang guard
  always @(posedge clock) begin
    cycles++;
    if (primary_sync_pulse_ff === 1'b1) begin
      prim_gap = cycles - last_prim;
      last_prim = cycles;
      p_cnt++;
    end
    if (secondary_sync_pulse_ff === 1'b1) begin
      sec_gap = cycles - last_prim;
      s_cnt++;
    end
    if (activate_set_ff === 1'b1) act_cnt++;
    if (application_event_request_clear_ff === 1'b1) app_cnt++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  // ===================================================================
  // Access tasks
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task put_net(input logic [11:0] a, input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      #1;
      net_wr = 1'b1;
      net_addr = a + 12'(i);
      net_wdata = v[8*i+:8];
    end
    @(posedge clock);
    #1;
    net_wr = 1'b0;
  endtask : put_net

  task put_host(input logic [11:0] a, input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      #1;
      host_wr = 1'b1;
      host_addr = a + 12'(i);
      host_wdata = v[8*i+:8];
    end
    @(posedge clock);
    #1;
    host_wr = 1'b0;
  endtask : put_host

  // Bytes are read one by one, lowest address first.
  task get_net(input logic [11:0] a, input int n, output logic [63:0] v);
    v = 64'h0;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      #1;
      net_rd = 1'b1;
      net_addr = a + 12'(i);
      @(posedge clock);
      #1;
      net_rd = 1'b0;
      v[8*i+:8] = net_rdata_ff;
    end
  endtask : get_net

  task end_frame;
    @(posedge clock);
    #1 net_frame_end = 1'b1;
    @(posedge clock);
    #1 net_frame_end = 1'b0;
  endtask : end_frame

  task automatic wait_on(ref int c, input int lim);
    int c0;
    c0 = c;
    repeat (lim) if (c == c0) @(posedge clock);
    #1;
    check(64'(c != c0), 64'h1);
  endtask : wait_on

  task results;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  // ===================================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clock);
    get_net(`DCSP_OFS_CYCLIC_START, 8, d); check(d, 64'h0);
    get_net(`DCSP_OFS_PRIMARY_CYCLE, 8, d); check(d, 64'h0);
    get_net(`DCSP_OFS_CAPTURE_ZERO_CTL, 2, d); check(d, 64'h0);
    get_net(`DCSP_OFS_CAPTURE_ZERO_STAT, 1, d); check(d, 64'h0);
    put_net(`DCSP_OFS_PRIMARY_CYCLE, 64'h3e8, 4);
    get_net(`DCSP_OFS_PRIMARY_CYCLE, 4, d); check(d, 64'h3e8);
    sync_owner_host = 1'b1;
    put_net(`DCSP_OFS_PRIMARY_CYCLE, 64'hdeadbeef, 4);
    get_net(`DCSP_OFS_PRIMARY_CYCLE, 4, d); check(d, 64'h3e8);
    put_host(`DCSP_OFS_SECONDARY_CYCLE, 64'h12c, 4);
    get_net(`DCSP_OFS_SECONDARY_CYCLE, 4, d); check(d, 64'h12c);
    sync_owner_host = 1'b0;
    put_net(`DCSP_OFS_NEXT_SECONDARY, 64'hffff_ffff_ffff_ffff, 8);
    get_net(`DCSP_OFS_NEXT_SECONDARY, 8, d); check(d, 64'h0);
    // Start far enough ahead that the refused write below lands first.
    t = 64'h0000_0005_0000_2008;
    put_net(`DCSP_OFS_CYCLIC_START, t, 8);
    get_net(`DCSP_OFS_CYCLIC_START, 8, d); check(d, t);
    unit_active = 1'b1;
    put_net(`DCSP_OFS_CYCLIC_START, t + 64'h500, 8);
    get_net(`DCSP_OFS_CYCLIC_START, 8, d); check(d, t);
    wait_on(p_cnt, 1000);
    get_net(`DCSP_OFS_CYCLIC_START, 8, d); check(d, t + 64'h3e8);
    wait_on(s_cnt, 200); check(64'(sec_gap), 64'd30);
    wait_on(p_cnt, 200); check(64'(prim_gap), 64'd100);
    unit_active = 1'b0;
    put_net(`DCSP_OFS_PRIMARY_CYCLE, 64'h0, 4);
    put_net(`DCSP_OFS_CYCLIC_START, system_time + 64'd2000, 8);
    unit_active = 1'b1;
    wait_on(p_cnt, 400);
    p_cnt = 0;
    repeat (300) @(posedge clock);
    #1 check(64'(p_cnt), 64'h0);
    unit_active = 1'b0;
    // Clear the upper half first so that the extension has to supply it.
    put_net(`DCSP_OFS_CYCLIC_START, 64'h0, 8);
    end_frame();
    get_net(`DCSP_OFS_CYCLIC_START, 8, d); check(d, 64'h0);
    auto_activate = 1'b1;
    t = {32'h5, system_time[31:0] + 32'h1000};
    put_net(`DCSP_OFS_CYCLIC_START, t, 4);
    end_frame();
    repeat (3) @(posedge clock);
    #1 check(64'(act_cnt != 0), 64'h1);
    get_net(`DCSP_OFS_CYCLIC_START, 8, d); check(d, t);
    auto_activate = 1'b0;
    put_net(`DCSP_OFS_CAPTURE_ZERO_CTL, 64'hff, 1);
    get_net(`DCSP_OFS_CAPTURE_ZERO_CTL, 1, d); check(d, 64'h3);
    capture_one_owner_host = 1'b1;
    put_net(`DCSP_OFS_CAPTURE_ONE_CTL, 64'h3, 1);
    get_net(`DCSP_OFS_CAPTURE_ONE_CTL, 1, d); check(d, 64'h0);
    put_host(`DCSP_OFS_CAPTURE_ONE_CTL, 64'h2, 1);
    get_net(`DCSP_OFS_CAPTURE_ONE_CTL, 1, d); check(d, 64'h2);
    t = system_time;
    capture_input_zero = 1'b1;
    repeat (4) @(posedge clock);
    get_net(`DCSP_OFS_CAPTURE_ZERO_STAT, 1, d); check(d, 64'h5);
    get_net(`DCSP_OFS_ZERO_RISE_TIME, 8, d); check(64'(d - t < 64'd40), 64'h1);
    get_net(`DCSP_OFS_CAPTURE_ZERO_STAT, 1, d); check(d, 64'h4);
    capture_input_zero = 1'b0;
    repeat (4) @(posedge clock);
    get_net(`DCSP_OFS_CAPTURE_ZERO_STAT, 1, d); check(d, 64'h2);
    get_net(`DCSP_OFS_ZERO_FALL_TIME, 8, d);
    get_net(`DCSP_OFS_CAPTURE_ZERO_STAT, 1, d); check(d, 64'h0);
    put_net(`DCSP_OFS_CAPTURE_ZERO_CTL, 64'h0, 1);
    t = system_time;
    capture_input_zero = 1'b1;
    repeat (4) @(posedge clock);
    get_net(`DCSP_OFS_CAPTURE_ZERO_STAT, 1, d); check(d, 64'h4);
    get_net(`DCSP_OFS_ZERO_RISE_TIME, 8, d); check(64'(d - t < 64'd40), 64'h1);
    host_write_ack_en = 1'b0;
    app_cnt = 0;
    @(posedge clock);
    #1 host_rd = 1'b1;
    host_addr = `DCSP_OFS_SECONDARY_STATUS;
    @(posedge clock);
    #1 host_rd = 1'b0;
    repeat (3) @(posedge clock);
    #1 check(64'(app_cnt), 64'h1);
    results();
  end
endmodule : dcsp_unit_test

`default_nettype wire
